// [pss_pkg.sv]
// constants and types shared by the platform supervisor register bank
package pss_pkg;
	// fixed slave address on the management bus
	localparam logic [6:0] I2C_DEV_ADDR   = 7'h31;

	// register offsets
	localparam logic [7:0] OFF_REVISION   = 8'h00;
	localparam logic [7:0] OFF_LOCK_CLEAR = 8'h03;
	localparam logic [7:0] OFF_PLANAR     = 8'h07;
	localparam logic [7:0] OFF_EN_LO      = 8'h08;
	localparam logic [7:0] OFF_EN_HI      = 8'h09;
	localparam logic [7:0] OFF_PG_LO      = 8'h0a;
	localparam logic [7:0] OFF_PG_HI      = 8'h0b;
	localparam logic [7:0] OFF_MAKER_0    = 8'h0c;
	localparam logic [7:0] OFF_MAKER_1    = 8'h0d;
	localparam logic [7:0] OFF_MAKER_2    = 8'h0e;
	localparam logic [7:0] OFF_MAKER_3    = 8'h0f;
	localparam logic [7:0] OFF_PANEL      = 8'h10;
	localparam logic [7:0] OFF_FAULT_LO   = 8'h18;
	localparam logic [7:0] OFF_FAULT_HI   = 8'h19;
	localparam logic [7:0] OFF_FACTORY    = 8'h33;

	// planar_state bit positions
	localparam int ST_MODE_SET = 7;
	localparam int ST_VIDEO    = 6;
	localparam int ST_CPU2     = 5;
	localparam int ST_TMO      = 4;
	localparam int ST_OFFL     = 3;
	localparam int ST_GEN      = 2;
	localparam int ST_REQ      = 1;
	localparam int ST_ACTIVE   = 0;

	// factory_force_bits fields and reset values
	localparam int FF_POWER_REQ = 0;
	localparam int FF_CPU2_ON   = 1;
	localparam int FF_CPU2_PRES = 2;
	localparam logic [7:0] FACTORY_RESET = 8'h00;
	localparam logic [7:0] FACTORY_MASK  = 8'h07;
	localparam logic [7:0] PANEL_RESET   = 8'h00;
	localparam logic [7:0] READ_ZERO     = 8'h00;

	// rail fields: sixteen bits, top one unused
	localparam int RAIL_W    = 16;
	localparam int RAIL_USED = 15;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int FADE_STEP_US  = 20000;
	localparam int FADE_STEP_CYC = FADE_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] LVL_DIM    = 4'h2;
	localparam logic [3:0] LVL_BRIGHT = 4'hf;

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_OFF, S_OFF_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
	} pss_i2c_e;
endpackage

// [pss_csr_bank.sv]
// register bank, i2c slave port and panel indicator logic of the supervisor
`timescale 1ns/1ns
module pss_csr_bank #(
	parameter logic [7:0]  REVISION    = 8'h00,
	parameter logic [31:0] MAKER_ID    = 32'h2058_5858, // arbitrary value
	parameter int          LED_N       = 4,
	parameter int          FADE_CYC    = pss_pkg::FADE_STEP_CYC
) (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           sda_out,
	output logic                           sda_oe,
	input  wire logic                      platform_power_request,
	input  wire logic                      mode_set_n,
	input  wire logic                      video_code_inhibit_n,
	input  wire logic                      cpu2_present_n,
	input  wire logic                      mgmt_boot_stage_in,
	input  wire logic                      mgmt_boot_done_n,
	input  wire logic [LED_N-1:0]          planar_led,
	input  wire logic [pss_pkg::RAIL_W-1:0] rail_good,
	input  wire logic                      seq_timeout_fault,
	input  wire logic                      seq_offline_fault,
	input  wire logic                      seq_general_fault,
	input  wire logic                      planar_active,
	input  wire logic [pss_pkg::RAIL_W-1:0] rail_enable,
	input  wire logic [pss_pkg::RAIL_W-1:0] rail_fault,
	output logic                           seq_power_request,
	output logic                           lockout_clear,
	output logic                           seq_restart,
	output logic                           cpu2_force_on,
	output logic                           cpu2_present,
	output logic                           rail_order_ok,
	output logic [LED_N-1:0]               panel_led_n
);
	import pss_pkg::*;

	localparam int PW = 8 + LED_N + RAIL_W;
	localparam int CW = $clog2(FADE_CYC);
	// idle level of each synchronised pin: bus high, request low, active-low pins and boot stage high, leds and good low
	localparam logic [PW-1:0] SYNC_IDLE = {2'b11, 1'b0, 5'b11111, {LED_N{1'b0}}, {RAIL_W{1'b0}}};

	// refuse shapes the logic cannot serve
	if (LED_N < 3 || LED_N > 4) begin : g_bad_led
		$error("LED_N must be 3 or 4");
	end
	if (FADE_CYC < 2) begin : g_bad_fade
		$error("FADE_CYC must be at least 2");
	end

	logic [PW-1:0]      sync1_q;
	logic [PW-1:0]      sync2_q;
	logic               scl_s;
	logic               sda_s;
	logic               scl_prev_q;
	logic               sda_prev_q;
	logic               req_s;
	logic               mode_set_s;
	logic               video_s;
	logic               cpu2_s;
	logic               stage_s;
	logic               boot_done_s;
	logic [LED_N-1:0]   led_s;
	logic [RAIL_W-1:0]  good_s;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_det;
	logic               stop_det;
	pss_i2c_e           st_q;
	logic [3:0]         bit_q;
	logic [7:0]         shift_q;
	logic [7:0]         tx_q;
	logic [7:0]         ptr_q;
	logic               rw_q;
	logic               nack_q;
	logic               sda_oe_q;
	logic               wr_evt;
	logic               rd_load;
	logic [7:0]         rd_data;
	logic [7:0]         panel_q;
	logic [7:0]         factory_q;
	logic               req_q;
	logic               clear_q;
	logic               restart_q;
	logic [RAIL_W-1:0]  en_live;
	logic [CW-1:0]      fade_cnt_q;
	logic               fade_tick;
	logic [5:0]         phase_q;
	logic [1:0]         slot3_q;
	logic [3:0]         pwm_q;
	logic [LED_N-1:0]   led_on;
	logic [LED_N-1:0]   led_n_q;

	// bus, request, strap, boot, led and rail-good pins cross two flops; reset to idle levels so no power request glitches out
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1_q <= SYNC_IDLE;
			sync2_q <= SYNC_IDLE;
		end else begin
			sync1_q <= {scl_in, sda_in, platform_power_request, mode_set_n, video_code_inhibit_n,
				cpu2_present_n, mgmt_boot_stage_in, mgmt_boot_done_n, planar_led, rail_good};
			sync2_q <= sync1_q;
		end
	end

	assign {scl_s, sda_s, req_s, mode_set_s, video_s, cpu2_s, stage_s, boot_done_s, led_s, good_s} = sync2_q;

	// previous bus levels for edge and start/stop detection
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// byte events seen by the register file
	assign wr_evt  = scl_fall && st_q == S_WR && bit_q == 4'h8;
	assign rd_load = scl_fall && ((st_q == S_ADDR_ACK && rw_q) || (st_q == S_RD_ACK && !nack_q));

	// live rail enables, top bit forced to zero
	assign en_live = {1'b0, rail_enable[RAIL_USED-1:0]};

	// read mux; anything unmapped or reserved reads zero
	always_comb begin
		rd_data = READ_ZERO;
		case (ptr_q)
			OFF_REVISION: rd_data = REVISION;
			OFF_PLANAR: begin
				rd_data[ST_MODE_SET] = ~mode_set_s;
				rd_data[ST_VIDEO]    = ~video_s;
				rd_data[ST_CPU2]     = cpu2_present;
				rd_data[ST_TMO]      = seq_timeout_fault;
				rd_data[ST_OFFL]     = seq_offline_fault;
				rd_data[ST_GEN]      = seq_general_fault;
				rd_data[ST_REQ]      = req_q;
				rd_data[ST_ACTIVE]   = planar_active;
			end
			OFF_EN_LO:    rd_data = en_live[7:0];
			OFF_EN_HI:    rd_data = en_live[15:8];
			OFF_PG_LO:    rd_data = good_s[7:0];
			OFF_PG_HI:    rd_data = {1'b0, good_s[14:8]};
			OFF_MAKER_0:  rd_data = MAKER_ID[7:0];
			OFF_MAKER_1:  rd_data = MAKER_ID[15:8];
			OFF_MAKER_2:  rd_data = MAKER_ID[23:16];
			OFF_MAKER_3:  rd_data = MAKER_ID[31:24];
			OFF_PANEL:    rd_data = panel_q;
			OFF_FAULT_LO: rd_data = rail_fault[7:0];
			OFF_FAULT_HI: rd_data = {1'b0, rail_fault[14:8]};
			OFF_FACTORY:  rd_data = factory_q;
			default:      rd_data = READ_ZERO;
		endcase
	end

	// i2c slave: sample on scl rise, change sda only after scl fall
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q     <= S_IDLE;
			bit_q    <= 4'h0;
			shift_q  <= 8'h00;
			tx_q     <= 8'h00;
			ptr_q    <= 8'h00;
			rw_q     <= 1'b0;
			nack_q   <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (start_det) begin
			// repeated start keeps the pointer so a read follows the offset
			st_q     <= S_ADDR;
			bit_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop_det) begin
			st_q     <= S_IDLE;
			sda_oe_q <= 1'b0;
		end else if (scl_rise) begin
			if (st_q == S_ADDR || st_q == S_OFF || st_q == S_WR) begin
				shift_q <= {shift_q[6:0], sda_s};
				bit_q   <= bit_q + 4'h1;
			end
			if (st_q == S_RD_ACK) begin
				nack_q <= sda_s;
			end
		end else if (scl_fall) begin
			case (st_q)
				S_ADDR: begin
					if (bit_q == 4'h8) begin
						if (shift_q[7:1] == I2C_DEV_ADDR) begin
							st_q     <= S_ADDR_ACK;
							rw_q     <= shift_q[0];
							sda_oe_q <= 1'b1;
						end else begin
							st_q <= S_IDLE;
						end
					end
				end
				S_ADDR_ACK: begin
					bit_q <= 4'h0;
					if (rw_q) begin
						st_q     <= S_RD;
						tx_q     <= rd_data;
						ptr_q    <= ptr_q + 8'h01;
						sda_oe_q <= ~rd_data[7];
						bit_q    <= 4'h1;
					end else begin
						st_q     <= S_OFF;
						sda_oe_q <= 1'b0;
					end
				end
				S_OFF: begin
					if (bit_q == 4'h8) begin
						st_q     <= S_OFF_ACK;
						ptr_q    <= shift_q;
						sda_oe_q <= 1'b1;
					end
				end
				S_OFF_ACK: begin
					st_q     <= S_WR;
					bit_q    <= 4'h0;
					sda_oe_q <= 1'b0;
				end
				S_WR: begin
					if (bit_q == 4'h8) begin
						st_q     <= S_WR_ACK;
						ptr_q    <= ptr_q + 8'h01;
						sda_oe_q <= 1'b1; // read-only targets still acked
					end
				end
				S_WR_ACK: begin
					st_q     <= S_WR;
					bit_q    <= 4'h0;
					sda_oe_q <= 1'b0;
				end
				S_RD: begin
					if (bit_q == 4'h8) begin
						st_q     <= S_RD_ACK;
						sda_oe_q <= 1'b0;
					end else begin
						sda_oe_q <= ~tx_q[3'(7 - bit_q)];
						bit_q    <= bit_q + 4'h1;
					end
				end
				S_RD_ACK: begin
					if (nack_q) begin
						st_q <= S_IDLE;
					end else begin
						st_q     <= S_RD;
						tx_q     <= rd_data;
						ptr_q    <= ptr_q + 8'h01;
						sda_oe_q <= ~rd_data[7];
						bit_q    <= 4'h1;
					end
				end
				default: begin
					st_q     <= S_IDLE;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_q;

	// panel code register, plain read/write
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			panel_q <= PANEL_RESET;
		end else if (wr_evt && ptr_q == OFF_PANEL) begin
			panel_q <= shift_q; // firmware restores zero after load
		end
	end

	// factory force bits; reserved upper bits never stored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			factory_q <= FACTORY_RESET;
		end else if (wr_evt && ptr_q == OFF_FACTORY) begin
			factory_q <= shift_q & FACTORY_MASK;
		end
	end

	// combined request and lockout release toward the sequencer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_q     <= 1'b0;
			clear_q   <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			req_q     <= req_s | factory_q[FF_POWER_REQ];
			clear_q   <= rd_load && ptr_q == OFF_LOCK_CLEAR;
			restart_q <= rd_load && ptr_q == OFF_LOCK_CLEAR && req_q;
		end
	end

	assign seq_power_request = req_q;
	assign lockout_clear     = clear_q;
	assign seq_restart       = restart_q;
	assign cpu2_force_on     = factory_q[FF_CPU2_ON];
	assign cpu2_present      = ~cpu2_s | factory_q[FF_CPU2_PRES];
	// sequencer health: enables must form a run from bit 0 upward
	assign rail_order_ok     = (en_live & (en_live + 16'h0001)) == 16'h0000;

	// fade step divider: one-cycle tick every FADE_CYC clocks
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fade_cnt_q <= '0;
		end else if (fade_tick) begin
			fade_cnt_q <= '0;
		end else begin
			fade_cnt_q <= fade_cnt_q + 1'b1;
		end
	end

	assign fade_tick = fade_cnt_q == CW'(FADE_CYC - 1);

	// fade phase, three-slot counter and pwm carrier
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_q <= 6'h00;
			slot3_q <= 2'h0;
			pwm_q   <= 4'h0;
		end else begin
			pwm_q <= pwm_q + 4'h1;
			if (fade_tick) begin
				phase_q <= phase_q + 6'h01;
				if (phase_q[3:0] == 4'hf) begin
					slot3_q <= (slot3_q == 2'h2) ? 2'h0 : slot3_q + 2'h1;
				end
			end
		end
	end

	// triangle brightness from a five-bit phase
	function automatic logic [3:0] tri_lvl(input logic [4:0] x);
		tri_lvl = x[4] ? ~x[3:0] : x[3:0];
	endfunction

	// panel source select: boot display, pass-through, or code override
	always_comb begin
		led_on = '0;
		for (int i = 0; i < LED_N; i++) begin
			if (boot_done_s) begin
				// controller still booting: block drives the panel itself
				if (stage_s) begin
					led_on[i] = tri_lvl(phase_q[4:0] + 5'(i * 8)) > pwm_q;
				end else begin
					led_on[i] = tri_lvl(phase_q[4:0]) > pwm_q;
				end
			end else if (panel_q == PANEL_RESET) begin
				led_on[i] = led_s[i];
			end else if (panel_q[LED_N]) begin
				led_on[i] = panel_q[i] && ((phase_q[3] ? LVL_BRIGHT : LVL_DIM) > pwm_q);
			end else begin
				led_on[i] = panel_q[i] && (((slot3_q == 2'h2) ? LVL_BRIGHT : LVL_DIM) > pwm_q);
			end
		end
	end

	// panel drivers are active low
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			led_n_q <= '1;
		end else begin
			led_n_q <= ~led_on;
		end
	end

	assign panel_led_n = led_n_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_off_taken;
		scl_fall && !start_det && !stop_det && st_q == S_OFF && bit_q == 4'h8;
	endsequence
	sequence s_clear_read;
		rd_load && !start_det && !stop_det && ptr_q == OFF_LOCK_CLEAR;
	endsequence

	property p_offset_ptr;
		s_off_taken |=> ptr_q == $past(shift_q) && st_q == S_OFF_ACK && sda_oe;
	endproperty
	a_offset_ptr: assert property (p_offset_ptr) else $error("offset not latched");

	property p_addr_miss;
		scl_fall && !start_det && !stop_det && st_q == S_ADDR && bit_q == 4'h8 && shift_q[7:1] != I2C_DEV_ADDR
			|=> st_q == S_IDLE && !sda_oe;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

	property p_clear_pulse;
		s_clear_read |=> lockout_clear ##1 !lockout_clear;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("lockout release missing");

	property p_restart;
		s_clear_read ##0 seq_power_request |=> seq_restart && lockout_clear;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not issued");

	property p_req_or;
		##1 seq_power_request == $past(req_s | factory_q[FF_POWER_REQ]);
	endproperty
	a_req_or: assert property (p_req_or) else $error("request not combined");

	property p_factory_rsvd;
		factory_q[7:3] == 5'h00 && cpu2_force_on == factory_q[FF_CPU2_ON];
	endproperty
	a_factory_rsvd: assert property (p_factory_rsvd) else $error("factory byte wrong");

	property p_ro_write;
		wr_evt && ptr_q != OFF_PANEL && ptr_q != OFF_FACTORY |=> $stable(panel_q) && $stable(factory_q);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

	property p_pass_through;
		!boot_done_s && panel_q == PANEL_RESET |=> panel_led_n == ~$past(led_s);
	endproperty
	a_pass_through: assert property (p_pass_through) else $error("panel not passed through");

	property p_dark_unlit;
		!boot_done_s && panel_q != PANEL_RESET && $stable(panel_q) |=> (panel_led_n | $past(panel_q[LED_N-1:0])) == '1;
	endproperty
	a_dark_unlit: assert property (p_dark_unlit) else $error("unlit led driven");

	property p_top_zero;
		ptr_q == OFF_EN_HI || ptr_q == OFF_FAULT_HI |-> !rd_data[7];
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("unused rail bit set");
endmodule

// [pss_bmc_model.sv]
// bus master model of the management controller on the i2c port
`timescale 1ns/1ns
module pss_bmc_model (
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	import pss_pkg::*;
	// quarter of the 800 ns bit period
	localparam int Q = 200;
	logic [7:0] rdata [0:3];
	logic       ack_ok;
	// idle bus: clock stands high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		ack_ok = 1'b1;
	end
	// data only moves while the clock is low
	task automatic bit_out(input logic b);
		scl = 1'b0;
		#Q sda_pull = ~b;
		#Q scl = 1'b1;
		#(2*Q);
	endtask
	task automatic bit_in(output logic b);
		scl = 1'b0;
		#Q sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q b = sda;
		#Q;
	endtask
	// serves as repeated start as well
	task automatic start_cond();
		scl = 1'b0;
		#Q sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b1;
		#Q;
	endtask
	task automatic stop_cond();
		scl = 1'b0;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#Q;
	endtask
	task automatic send_byte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(a);
		if (a !== 1'b0) ack_ok = 1'b0;
	endtask
	// nack on the last byte ends the read
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_in(b);
			d[i] = b;
		end
		bit_out(last);
	endtask
	// offset byte first, then one data byte
	task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
		start_cond();
		send_byte({I2C_DEV_ADDR, 1'b0});
		send_byte(off);
		send_byte(d);
		stop_cond();
	endtask
	// offset, repeated start, then n bytes from that offset
	task automatic read_regs(input logic [7:0] off, input int n);
		start_cond();
		send_byte({I2C_DEV_ADDR, 1'b0});
		send_byte(off);
		start_cond();
		send_byte({I2C_DEV_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			recv_byte(i == n - 1, rdata[i]);
		end
		stop_cond();
	endtask
	task automatic probe(input logic [6:0] a, output logic acked);
		logic b;
		start_cond();
		for (int i = 6; i >= 0; i--) begin
			bit_out(a[i]);
		end
		bit_out(1'b0);
		bit_in(b);
		stop_cond();
		acked = (b === 1'b0);
	endtask
endmodule

// [platform_supervisor_csr_bank_tb_top.sv]
// self-checking bench of the supervisor register bank
`timescale 1ns/1ns
module platform_supervisor_csr_bank_tb_top;
	import pss_pkg::*;
	localparam logic [7:0]  REV   = 8'h03;
	localparam logic [31:0] MAKER = 32'h4443_4241; // arbitrary value
	logic        clock, rst, scl, m_pull, sda, sda_out, sda_oe;
	logic        req, mode_n, video_n, cpu2_n, stage, done_n;
	logic        tmo, offl, gen, act, seq_req, clr, rstrt, force_on, pres, order_ok;
	logic [3:0]  pled, led_n;
	logic [15:0] good, en, flt;
	int          failures, check_count, clr_cnt, rstrt_cnt;
	// open drain with pull-up, either end may pull low
	assign sda = ~(m_pull | sda_oe);
	pss_csr_bank #(.REVISION(REV), .MAKER_ID(MAKER), .LED_N(4), .FADE_CYC(4)) pss_csr_bank_inst (
		.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.platform_power_request(req), .mode_set_n(mode_n), .video_code_inhibit_n(video_n),
		.cpu2_present_n(cpu2_n), .mgmt_boot_stage_in(stage), .mgmt_boot_done_n(done_n),
		.planar_led(pled), .rail_good(good), .seq_timeout_fault(tmo), .seq_offline_fault(offl),
		.seq_general_fault(gen), .planar_active(act), .rail_enable(en), .rail_fault(flt),
		.seq_power_request(seq_req), .lockout_clear(clr), .seq_restart(rstrt),
		.cpu2_force_on(force_on), .cpu2_present(pres), .rail_order_ok(order_ok), .panel_led_n(led_n));
	pss_bmc_model pss_bmc_model_inst (.scl(scl), .sda_pull(m_pull), .sda(sda));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// single-cycle pulses are counted, not sampled
	always @(posedge clock) begin
		if (clr === 1'b1) clr_cnt++;
		if (rstrt === 1'b1) rstrt_cnt++;
	end
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] off, input int n);
		tick();
		pss_bmc_model_inst.read_regs(off, n);
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		tick();
		pss_bmc_model_inst.write_reg(off, d);
	endtask
	task automatic done(input string name);
		check({7'h0, pss_bmc_model_inst.ack_ok}, 8'h01, "ack");
		$display("test %s finished", name);
	endtask
	task automatic t_reset();
		check({4'h0, led_n}, 8'h0f, "leds in reset");
		check({6'h0, sda_out, sda_oe}, 8'h00, "sda released in reset");
		rst = 1'b0;
		repeat (3) tick();
		rd(OFF_PANEL, 1);
		check(pss_bmc_model_inst.rdata[0], PANEL_RESET, "panel reset");
		rd(OFF_FACTORY, 1);
		check(pss_bmc_model_inst.rdata[0], FACTORY_RESET, "factory reset");
		done("reset");
	endtask
	task automatic t_ident();
		logic [7:0] gaps [0:2];
		gaps = '{8'h05, 8'h06, 8'h20};
		wr(OFF_REVISION, 8'hff);
		rd(OFF_REVISION, 1);
		check(pss_bmc_model_inst.rdata[0], REV, "revision");
		rd(OFF_MAKER_0, 4);
		for (int i = 0; i < 4; i++) begin
			check(pss_bmc_model_inst.rdata[i], MAKER[8*i +: 8], "maker");
		end
		for (int i = 0; i < 3; i++) begin
			rd(gaps[i], 1);
			check(pss_bmc_model_inst.rdata[0], READ_ZERO, "unmapped");
		end
		done("ident");
	endtask
	task automatic t_status();
		logic [7:0] st;
		for (int k = 0; k < 2; k++) begin
			st = (k == 0) ? 8'ha6 : 8'h59;
			{mode_n, video_n, cpu2_n} = ~st[7:5];
			{tmo, offl, gen, req, act} = st[4:0];
			rd(OFF_PLANAR, 1);
			check(pss_bmc_model_inst.rdata[0], st, "status");
			check({7'h0, seq_req}, {7'h0, st[1]}, "request");
		end
		{mode_n, video_n, cpu2_n, req, act} = 5'b11100;
		done("status");
	endtask
	task automatic t_rails();
		logic [31:0] e4;
		e4 = 32'h1a5c_003f;
		en = 16'h803f;
		good = 16'h9a5c;
		flt = 16'hc3a1;
		rd(OFF_EN_LO, 4);
		for (int i = 0; i < 4; i++) begin
			check(pss_bmc_model_inst.rdata[i], e4[8*i +: 8], "rails");
		end
		rd(OFF_FAULT_LO, 2);
		check(pss_bmc_model_inst.rdata[0], 8'ha1, "fault low");
		check(pss_bmc_model_inst.rdata[1], 8'h43, "fault high");
		check({7'h0, order_ok}, 8'h01, "order good");
		en = 16'h0005;
		tick();
		check({7'h0, order_ok}, 8'h00, "order gap");
		done("rails");
	endtask
	task automatic t_addr();
		logic a0, a1, a2;
		tick();
		pss_bmc_model_inst.probe(7'h30, a0);
		pss_bmc_model_inst.probe(7'h32, a1);
		pss_bmc_model_inst.probe(I2C_DEV_ADDR, a2);
		check({5'h0, a0, a1, a2}, 8'h01, "address");
		done("addr");
	endtask
	task automatic t_factory();
		wr(OFF_FACTORY, 8'hff);
		rd(OFF_FACTORY, 1);
		check(pss_bmc_model_inst.rdata[0], FACTORY_MASK, "factory");
		check({5'h0, seq_req, force_on, pres}, 8'h07, "forces on");
		rd(OFF_PLANAR, 1);
		check(pss_bmc_model_inst.rdata[0] & 8'h20, 8'h20, "forced presence");
		wr(OFF_FACTORY, 8'h00);
		tick();
		check({5'h0, seq_req, force_on, pres}, 8'h00, "forces off");
		done("factory");
	endtask
	task automatic t_clear();
		for (int k = 1; k >= 0; k--) begin
			req = k[0];
			repeat (4) tick();
			clr_cnt = 0;
			rstrt_cnt = 0;
			rd(OFF_LOCK_CLEAR, 1);
			check(pss_bmc_model_inst.rdata[0], READ_ZERO, "clear value");
			check(clr_cnt[7:0], 8'h01, "clear pulse");
			check(rstrt_cnt[7:0], {7'h0, k[0]}, "restart pulse");
		end
		done("clear");
	endtask
	task automatic watch(input int n, output logic [3:0] lo, output int lows, output logic apart);
		lo = 4'h0;
		lows = 0;
		apart = 1'b0;
		repeat (8) tick();
		repeat (n) begin
			tick();
			lo = lo | ~led_n;
			lows += (led_n[0] == 1'b0);
			if (led_n != {4{led_n[0]}}) apart = 1'b1;
		end
	endtask
	task automatic t_panel();
		logic [3:0] lo;
		logic       ap;
		int         n_s, n_f;
		pled = 4'b1010;
		repeat (4) tick();
		check({4'h0, led_n}, 8'h05, "pass");
		wr(OFF_PANEL, 8'he5);
		watch(1920, lo, n_s, ap);
		check({4'h0, lo}, 8'h05, "slow lit");
		wr(OFF_PANEL, 8'h15);
		watch(1920, lo, n_f, ap);
		check({4'h0, lo}, 8'h05, "fast lit");
		check({7'h0, n_f > n_s}, 8'h01, "fast brighter");
		done_n = 1'b1;
		watch(2000, lo, n_s, ap);
		check({3'h0, lo, ap}, 8'h1f, "sequential");
		stage = 1'b0;
		watch(2000, lo, n_s, ap);
		check({3'h0, lo, ap}, 8'h1e, "unison");
		done_n = 1'b0;
		stage = 1'b1;
		wr(OFF_PANEL, 8'h00);
		repeat (4) tick();
		check({4'h0, led_n}, {4'h0, ~pled}, "pass again");
		done("panel");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		{rst, req, mode_n, video_n, cpu2_n, stage, done_n} = 7'b1011110;
		{tmo, offl, gen, act} = 4'h0;
		pled = 4'h0;
		{good, en, flt} = '0;
		{failures, check_count, clr_cnt, rstrt_cnt} = '0;
		repeat (2) tick();
		t_reset();
		t_ident();
		t_status();
		t_rails();
		t_addr();
		t_factory();
		t_clear();
		t_panel();
		final_report();
	end
	// run should take about one and a half ms
	initial begin
		#6000000;
		failures++;
		final_report();
	end
endmodule
